// >>> shared/clkgen_pkg.sv
package clkgen_pkg;
  localparam logic [15:0] ADDR_CSR = 16'h1C80;
  localparam logic [15:0] ADDR_CK3 = 16'h1C82;
  localparam logic [15:0] ADDR_MULT = 16'h1C88;
  localparam logic [15:0] ADDR_DIV0 = 16'h1C8A;
  localparam logic [15:0] ADDR_DIV1 = 16'h1C8C;
  localparam logic [15:0] ADDR_DIV2 = 16'h1C8E;
  localparam logic [15:0] ADDR_DIV3 = 16'h1C90;
  localparam logic [15:0] ADDR_OSCDIV = 16'h1C92;
  localparam logic [15:0] ADDR_WAKE = 16'h1C98;
  localparam logic [15:0] ADDR_CLKOUT = 16'h8400;
  localparam logic [15:0] ADDR_CLOCK_MODE_CONTROL = 16'h8C00;

  localparam int CSR_STABLE_BIT = 6;
  localparam int CSR_LOCK_BIT = 5;
  localparam int CSR_RST_BIT = 3;
  localparam int CSR_OSCPD_BIT = 2;
  localparam int CSR_PLLPD_BIT = 1;
  localparam int CSR_EN_BIT = 0;
  localparam int DIV_EN_BIT = 15;
  localparam int RATIO_MSB = 4;
  localparam int CLOCK_MODE_CONTROL_MODE0_BIT = 0;

  localparam logic RST_RESET = 1'b1;
  localparam logic OSCPD_RESET = 1'b0;
  localparam logic PLLPD_RESET = 1'b0;
  localparam logic EN_RESET = 1'b0;
  localparam logic DIV_EN_RESET = 1'b1;
  localparam logic [4:0] MULT_RESET = 5'h00;
  localparam logic [4:0] MULT_MIN = 5'h02;
  localparam logic [4:0] MULT_MAX = 5'h0F;
  localparam logic [4:0] DIV0_RATIO_RESET = 5'h00;
  localparam logic [4:0] DIVN_RATIO_RESET = 5'h03;
  localparam logic [15:0] CK3_RESET = 16'h000B;
  localparam logic [15:0] PLAIN_RESET = 16'h0000;

  localparam int CLK_PERIOD_PS = 8000;
  localparam int OSC_STABLE_CYCLES = 41032;
  localparam int LOCK_QUAL_NS = 200;
  localparam int LOCK_QUAL_CYCLES = (LOCK_QUAL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef enum logic [1:0] {
    LK_RESET = 2'b00,
    LK_ACQUIRE = 2'b01,
    LK_LOCKED = 2'b10
  } lock_state_t;
endpackage : clkgen_pkg

// >>> shared/settle_if.sv
`timescale 1ns/10ps
`default_nettype none
interface settle_if;
  logic run;
  logic done;
  modport counter (input run, output done);
  modport user (output run, input done);
endinterface : settle_if
`default_nettype wire

// >>> design/sync2.sv
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge mclk) begin
    if (reset) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : sync2
`default_nettype wire

// >>> design/settle_counter.sv
`timescale 1ns/10ps
`default_nettype none
// counts consecutive cycles of run; done holds while run stays high
module settle_counter #(
  parameter int unsigned COUNT = 16
) (
  input wire logic mclk,
  input wire logic reset,
  settle_if.counter s
);
  localparam int unsigned CW = $clog2(COUNT + 1);
  localparam logic [CW-1:0] LAST = CW'(COUNT);
  logic [CW-1:0] cnt;

  always_ff @(posedge mclk) begin
    if (reset || !s.run) begin
      cnt <= '0;
    end else if (cnt != LAST) begin
      cnt <= cnt + CW'(1);
    end
  end

  assign s.done = (cnt == LAST);
endmodule : settle_counter
`default_nettype wire

// >>> design/clock_gen_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module clock_gen_ctrl #(
  parameter int unsigned OSC_COUNT = clkgen_pkg::OSC_STABLE_CYCLES,
  parameter int unsigned LOCK_QUAL = clkgen_pkg::LOCK_QUAL_CYCLES
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [15:0] io_wdata,
  output logic [15:0] io_rdata,
  output logic io_rvalid,
  input wire logic pll_lock_in,
  input wire logic clockgen_idle_flag,
  input wire logic osc_count_disable,
  input wire logic test_mode,
  output logic pll_reset_out,
  output logic pll_power_down_out,
  output logic pll_path_enable_out,
  output logic osc_power_down_out,
  output logic [4:0] pll_mult_out,
  output logic prescaler_enable_out,
  output logic [4:0] prescaler_ratio_out,
  output logic fast_div_enable_out,
  output logic [4:0] fast_div_ratio_out,
  output logic slow_div_enable_out,
  output logic [4:0] slow_div_ratio_out,
  output logic ext_mem_div_enable_out,
  output logic [4:0] ext_mem_div_ratio_out,
  output logic [15:0] core_clock_source_out
);
  logic lock_sync;
  logic idle_sync;
  logic osc_dis_sync;
  logic test_sync;
  logic oscillator_power_down;
  logic [4:0] mult_field;
  logic [15:0] oscillator_output_divider;
  logic [15:0] wakeup_enable;
  logic [15:0] clock_output_select;
  logic [15:0] clock_mode_control;
  logic lock_flag;
  clkgen_pkg::lock_state_t lock_st;
  clkgen_pkg::lock_state_t next_lock_st;

  // pins from the analog macro and idle logic are asynchronous here
  sync2 #(.WIDTH(4)) pin_sync (
    .mclk(mclk),
    .reset(reset),
    .d({pll_lock_in, clockgen_idle_flag, osc_count_disable, test_mode}),
    .q({lock_sync, idle_sync, osc_dis_sync, test_sync})
  );

  // address decode on the I/O word space
  logic sel_csr;
  logic sel_ck3;
  logic sel_mult;
  logic sel_div0;
  logic sel_div1;
  logic sel_div2;
  logic sel_div3;
  logic sel_oscdiv;
  logic sel_wake;
  logic sel_clkout;
  logic sel_clock_mode_control;
  assign sel_csr = (io_addr == clkgen_pkg::ADDR_CSR);
  assign sel_ck3 = (io_addr == clkgen_pkg::ADDR_CK3);
  assign sel_mult = (io_addr == clkgen_pkg::ADDR_MULT);
  assign sel_div0 = (io_addr == clkgen_pkg::ADDR_DIV0);
  assign sel_div1 = (io_addr == clkgen_pkg::ADDR_DIV1);
  assign sel_div2 = (io_addr == clkgen_pkg::ADDR_DIV2);
  assign sel_div3 = (io_addr == clkgen_pkg::ADDR_DIV3);
  assign sel_oscdiv = (io_addr == clkgen_pkg::ADDR_OSCDIV);
  assign sel_wake = (io_addr == clkgen_pkg::ADDR_WAKE);
  assign sel_clkout = (io_addr == clkgen_pkg::ADDR_CLKOUT);
  assign sel_clock_mode_control = (io_addr == clkgen_pkg::ADDR_CLOCK_MODE_CONTROL);

  logic wr_csr;
  logic wr_mult;
  logic wr_div0;
  logic wr_div3;
  logic mult_legal;
  logic clk_mode_bit0;
  assign wr_csr = io_wr && sel_csr;
  assign wr_mult = io_wr && sel_mult;
  assign wr_div0 = io_wr && sel_div0;
  assign wr_div3 = io_wr && sel_div3;
  assign mult_legal = (io_wdata[4:0] >= clkgen_pkg::MULT_MIN)
    && (io_wdata[4:0] <= clkgen_pkg::MULT_MAX);
  assign clk_mode_bit0 = clock_mode_control[clkgen_pkg::CLOCK_MODE_CONTROL_MODE0_BIT];

  // control bits; reserved write bits simply have no storage
  always_ff @(posedge mclk) begin
    if (reset) begin
      pll_reset_out <= clkgen_pkg::RST_RESET;
      oscillator_power_down <= clkgen_pkg::OSCPD_RESET;
      pll_power_down_out <= clkgen_pkg::PLLPD_RESET;
      pll_path_enable_out <= clkgen_pkg::EN_RESET;
    end else if (wr_csr) begin
      pll_reset_out <= io_wdata[clkgen_pkg::CSR_RST_BIT];
      oscillator_power_down <= io_wdata[clkgen_pkg::CSR_OSCPD_BIT];
      pll_power_down_out <= io_wdata[clkgen_pkg::CSR_PLLPD_BIT];
      pll_path_enable_out <= io_wdata[clkgen_pkg::CSR_EN_BIT];
    end
  end

  // field keeps what was written; the PLL sees the reset code 0 until a legal factor is written
  always_ff @(posedge mclk) begin
    if (reset) begin
      mult_field <= clkgen_pkg::MULT_RESET;
      pll_mult_out <= clkgen_pkg::MULT_RESET;
    end else if (wr_mult) begin
      mult_field <= io_wdata[4:0];
      if (mult_legal) begin
        pll_mult_out <= io_wdata[4:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      prescaler_enable_out <= clkgen_pkg::DIV_EN_RESET;
      prescaler_ratio_out <= clkgen_pkg::DIV0_RATIO_RESET;
    end else if (wr_div0) begin
      prescaler_enable_out <= io_wdata[clkgen_pkg::DIV_EN_BIT];
      prescaler_ratio_out <= io_wdata[clkgen_pkg::RATIO_MSB:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      fast_div_enable_out <= clkgen_pkg::DIV_EN_RESET;
      fast_div_ratio_out <= clkgen_pkg::DIVN_RATIO_RESET;
    end else if (io_wr && sel_div1) begin
      fast_div_enable_out <= io_wdata[clkgen_pkg::DIV_EN_BIT];
      fast_div_ratio_out <= io_wdata[clkgen_pkg::RATIO_MSB:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      slow_div_enable_out <= clkgen_pkg::DIV_EN_RESET;
      slow_div_ratio_out <= clkgen_pkg::DIVN_RATIO_RESET;
    end else if (io_wr && sel_div2) begin
      slow_div_enable_out <= io_wdata[clkgen_pkg::DIV_EN_BIT];
      slow_div_ratio_out <= io_wdata[clkgen_pkg::RATIO_MSB:0];
    end
  end

  // divider3 sits after the core mux, so a core retune moves it too;
  // no range check: keeping it at or under the limits is software's job
  always_ff @(posedge mclk) begin
    if (reset) begin
      ext_mem_div_enable_out <= clkgen_pkg::DIV_EN_RESET;
      ext_mem_div_ratio_out <= clkgen_pkg::DIVN_RATIO_RESET;
    end else if (wr_div3) begin
      ext_mem_div_enable_out <= io_wdata[clkgen_pkg::DIV_EN_BIT];
      ext_mem_div_ratio_out <= io_wdata[clkgen_pkg::RATIO_MSB:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      core_clock_source_out <= clkgen_pkg::CK3_RESET;
      oscillator_output_divider <= clkgen_pkg::PLAIN_RESET;
      wakeup_enable <= clkgen_pkg::PLAIN_RESET;
      clock_output_select <= clkgen_pkg::PLAIN_RESET;
      clock_mode_control <= clkgen_pkg::PLAIN_RESET;
    end else if (io_wr) begin
      if (sel_ck3) begin
        core_clock_source_out <= io_wdata;
      end
      if (sel_oscdiv) begin
        oscillator_output_divider <= io_wdata;
      end
      if (sel_wake) begin
        wakeup_enable <= io_wdata;
      end
      if (sel_clkout) begin
        clock_output_select <= io_wdata;
      end
      if (sel_clock_mode_control) begin
        clock_mode_control <= io_wdata;
      end
    end
  end

  // mode bit0 set: no wait for the idle handshake
  logic next_osc_pd;
  assign next_osc_pd = oscillator_power_down && (clk_mode_bit0 || idle_sync);

  always_ff @(posedge mclk) begin
    if (reset) begin
      osc_power_down_out <= 1'b0;
    end else begin
      osc_power_down_out <= next_osc_pd;
    end
  end

  // oscillator start-up count restarts each time the oscillator wakes
  settle_if osc_s ();
  assign osc_s.run = !osc_power_down_out;
  settle_counter #(.COUNT(OSC_COUNT)) osc_count (
    .mclk(mclk),
    .reset(reset),
    .s(osc_s)
  );
  logic osc_stable;
  assign osc_stable = osc_s.done || osc_dis_sync || test_sync;

  // lock must hold for a qualification time so a glitch never reads as lock
  settle_if lock_s ();
  assign lock_s.run = (lock_st == clkgen_pkg::LK_ACQUIRE) && lock_sync;
  settle_counter #(.COUNT(LOCK_QUAL)) lock_count (
    .mclk(mclk),
    .reset(reset),
    .s(lock_s)
  );

  logic pll_halted;
  assign pll_halted = pll_reset_out || pll_power_down_out;

  always_comb begin
    next_lock_st = lock_st;
    case (lock_st)
      clkgen_pkg::LK_RESET: begin
        if (!pll_halted) begin
          next_lock_st = clkgen_pkg::LK_ACQUIRE;
        end
      end
      clkgen_pkg::LK_ACQUIRE: begin
        if (pll_halted) begin
          next_lock_st = clkgen_pkg::LK_RESET;
        end else if (lock_s.done) begin
          next_lock_st = clkgen_pkg::LK_LOCKED;
        end
      end
      clkgen_pkg::LK_LOCKED: begin
        if (pll_halted) begin
          next_lock_st = clkgen_pkg::LK_RESET;
        end else if (!lock_sync) begin
          next_lock_st = clkgen_pkg::LK_ACQUIRE;
        end
      end
      default: begin
        next_lock_st = clkgen_pkg::LK_RESET;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      lock_st <= clkgen_pkg::LK_RESET;
      lock_flag <= 1'b0;
    end else begin
      lock_st <= next_lock_st;
      lock_flag <= (next_lock_st == clkgen_pkg::LK_LOCKED);
    end
  end

  // read path; reserved and unmapped bits are zero
  logic [15:0] csr_word;
  logic [15:0] rd_word;
  assign csr_word = {9'h000, osc_stable, lock_flag, 1'b0, pll_reset_out,
    oscillator_power_down, pll_power_down_out, pll_path_enable_out};
  assign rd_word =
    sel_csr ? csr_word :
    sel_ck3 ? core_clock_source_out :
    sel_mult ? {11'h000, mult_field} :
    sel_div0 ? {prescaler_enable_out, 10'h000, prescaler_ratio_out} :
    sel_div1 ? {fast_div_enable_out, 10'h000, fast_div_ratio_out} :
    sel_div2 ? {slow_div_enable_out, 10'h000, slow_div_ratio_out} :
    sel_div3 ? {ext_mem_div_enable_out, 10'h000, ext_mem_div_ratio_out} :
    sel_oscdiv ? oscillator_output_divider :
    sel_wake ? wakeup_enable :
    sel_clkout ? clock_output_select :
    sel_clock_mode_control ? clock_mode_control :
    16'h0000;

  always_ff @(posedge mclk) begin
    if (reset) begin
      io_rdata <= 16'h0000;
      io_rvalid <= 1'b0;
    end else begin
      io_rdata <= io_rd ? rd_word : 16'h0000;
      io_rvalid <= io_rd;
    end
  end

  // helper: cycles since the oscillator last woke, for the stable check
  logic [31:0] osc_since;
  always_ff @(posedge mclk) begin
    if (reset || osc_power_down_out) begin
      osc_since <= 32'h00000000;
    end else if (osc_since != 32'hFFFFFFFF) begin
      osc_since <= osc_since + 32'h00000001;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  a_csr_rsvd_zero: assert property (
    $past(io_rd && sel_csr) |-> io_rdata[15:7] == 9'h000 && !io_rdata[4])
    else $error("reserved control/status bits read nonzero");

  a_mult_rsvd_zero: assert property (
    $past(io_rd && sel_mult) |-> io_rdata[15:5] == 11'h000)
    else $error("reserved multiplier bits read nonzero");

  a_mult_readback: assert property (
    (wr_mult ##1 !wr_mult ##1 (io_rd && sel_mult))
      |=> io_rvalid && io_rdata[4:0] == $past(io_wdata[4:0], 3))
    else $error("multiplier word does not read back at its address");

  a_stable_wait: assert property (
    osc_stable |-> (osc_since >= OSC_COUNT || osc_dis_sync || test_sync))
    else $error("stable flag set before oscillator count finished");

  a_lock_drop: assert property (
    pll_halted |=> !lock_flag [*2])
    else $error("lock flag high while PLL held in reset or power-down");

  a_lock_cause: assert property (
    $rose(lock_flag) |-> $past(lock_sync) && !$past(pll_halted))
    else $error("lock flag rose without a lock indication");

  a_oscpd_idle: assert property (
    (oscillator_power_down && !clk_mode_bit0 && !idle_sync) |=> !osc_power_down_out)
    else $error("oscillator powered down before idle");

  a_oscpd_now: assert property (
    (wr_csr && io_wdata[clkgen_pkg::CSR_OSCPD_BIT] && clk_mode_bit0 && !(io_wr && sel_clock_mode_control))
      |-> ##2 osc_power_down_out)
    else $error("oscillator power-down not immediate in mode one");

  a_reset_values: assert property (
    $fell(reset) |-> pll_reset_out && !pll_power_down_out && !pll_path_enable_out
      && prescaler_enable_out && prescaler_ratio_out == 5'h00 && pll_mult_out == 5'h00)
    else $error("control bits wrong after reset");

  a_path_select: assert property (
    wr_csr |=> pll_path_enable_out == $past(io_wdata[clkgen_pkg::CSR_EN_BIT]))
    else $error("PLL path select did not follow the write");

  a_prescale_write: assert property (
    wr_div0 |=> prescaler_ratio_out == $past(io_wdata[4:0])
      && prescaler_enable_out == $past(io_wdata[15]))
    else $error("prescaler fields did not follow the write");

  a_mult_legal: assert property (
    $changed(pll_mult_out) |-> pll_mult_out >= clkgen_pkg::MULT_MIN
      && pll_mult_out <= clkgen_pkg::MULT_MAX)
    else $error("reserved multiplier code reached the PLL");

  a_div3_write: assert property (
    wr_div3 |=> ext_mem_div_ratio_out == $past(io_wdata[4:0])
      && ext_mem_div_enable_out == $past(io_wdata[15]))
    else $error("divider3 fields did not follow the write");

  c_lock_gained: cover property (!lock_flag ##1 lock_flag);
  c_osc_down: cover property ($rose(osc_power_down_out));
  c_div3_retune: cover property (wr_div3 ##[1:20] (io_rd && sel_div3));
endmodule : clock_gen_ctrl
`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic mclk;
  logic reset;
  logic [15:0] io_addr;
  logic io_wr;
  logic io_rd;
  logic [15:0] io_wdata;
  logic [15:0] io_rdata;
  logic io_rvalid;
  logic pll_lock_in;
  logic clockgen_idle_flag;
  logic osc_count_disable;
  logic test_mode;
  logic pll_reset_out;
  logic pll_power_down_out;
  logic pll_path_enable_out;
  logic osc_power_down_out;
  logic [4:0] pll_mult_out;
  logic prescaler_enable_out;
  logic [4:0] prescaler_ratio_out;
  logic fast_div_enable_out;
  logic [4:0] fast_div_ratio_out;
  logic slow_div_enable_out;
  logic [4:0] slow_div_ratio_out;
  logic ext_mem_div_enable_out;
  logic [4:0] ext_mem_div_ratio_out;
  logic [15:0] core_clock_source_out;
  int mismatches;
  int checked;
  // address, reset value, writable mask; the last entry is an unmapped hole
  logic [15:0] map_addr [12] = '{16'h1C80, 16'h1C82, 16'h1C88, 16'h1C8A, 16'h1C8C, 16'h1C8E,
    16'h1C90, 16'h1C92, 16'h1C98, 16'h8400, 16'h8C00, 16'h1C84};
  logic [15:0] map_rst [12] = '{16'h0008, 16'h000B, 16'h0000, 16'h8000, 16'h8003, 16'h8003,
    16'h8003, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  logic [15:0] map_mask [12] = '{16'h0000, 16'hFFFF, 16'h001F, 16'h801F, 16'h801F, 16'h801F,
    16'h801F, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0000};

  // counts shortened so the run stays short
  clock_gen_ctrl #(
    .OSC_COUNT(20),
    .LOCK_QUAL(3)
  ) u_dut (
    .mclk(mclk), .reset(reset), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
    .pll_lock_in(pll_lock_in), .clockgen_idle_flag(clockgen_idle_flag),
    .osc_count_disable(osc_count_disable), .test_mode(test_mode),
    .pll_reset_out(pll_reset_out), .pll_power_down_out(pll_power_down_out),
    .pll_path_enable_out(pll_path_enable_out), .osc_power_down_out(osc_power_down_out),
    .pll_mult_out(pll_mult_out), .prescaler_enable_out(prescaler_enable_out),
    .prescaler_ratio_out(prescaler_ratio_out), .fast_div_enable_out(fast_div_enable_out),
    .fast_div_ratio_out(fast_div_ratio_out), .slow_div_enable_out(slow_div_enable_out),
    .slow_div_ratio_out(slow_div_ratio_out), .ext_mem_div_enable_out(ext_mem_div_enable_out),
    .ext_mem_div_ratio_out(ext_mem_div_ratio_out), .core_clock_source_out(core_clock_source_out)
  );

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask : idle

  // one-cycle strobe, then a quiet cycle so no strobe is assigned twice at one edge
  task automatic wr(input logic [15:0] addr, input logic [15:0] data);
    io_addr = addr;
    io_wdata = data;
    io_wr = 1'b1;
    @(negedge mclk);
    io_wr = 1'b0;
    @(negedge mclk);
  endtask : wr

  task automatic rd(input logic [15:0] addr, input logic [15:0] exp);
    io_addr = addr;
    io_rd = 1'b1;
    @(negedge mclk);
    io_rd = 1'b0;
    check("read valid", {15'h0000, io_rvalid}, 16'h0001);
    check("read data", io_rdata, exp);
    @(negedge mclk);
  endtask : rd

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (5000) @(posedge mclk);
    mismatches++;
    end_of_test();
  end

  initial begin
    reset = 1'b1;
    io_addr = 16'h0000;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 16'h0000;
    pll_lock_in = 1'b0;
    clockgen_idle_flag = 1'b0;
    osc_count_disable = 1'b0;
    test_mode = 1'b0;
    mismatches = 0;
    checked = 0;
    repeat (12) @(negedge mclk);
    reset = 1'b0;
    @(negedge mclk);
    // reset values and map, stable still low right after reset
    for (int i = 0; i < 12; i++) rd(map_addr[i], map_rst[i]);
    check("mult out", {11'h000, pll_mult_out}, 16'h0000);
    // reserved bits read zero; unmapped writes vanish
    for (int i = 1; i < 12; i++) begin
      wr(map_addr[i], 16'hFFFF);
      rd(map_addr[i], map_mask[i]);
    end
    check("mult reserved code", {11'h000, pll_mult_out}, 16'h0000);
    check("prescaler", {prescaler_enable_out, 10'h000, prescaler_ratio_out}, 16'h801F);
    check("ext mem div", {ext_mem_div_enable_out, 10'h000, ext_mem_div_ratio_out}, 16'h801F);
    wr(clkgen_pkg::ADDR_DIV0, 16'h0000);
    check("prescaler off", {prescaler_enable_out, 10'h000, prescaler_ratio_out}, 16'h0000);
    wr(clkgen_pkg::ADDR_DIV3, 16'h0001);
    check("ext mem div", {ext_mem_div_enable_out, 10'h000, ext_mem_div_ratio_out}, 16'h0001);
    // multiplier bounds: 2 and 15 pass, 1 and 16 are held back
    wr(clkgen_pkg::ADDR_MULT, 16'h0002);
    check("mult min", {11'h000, pll_mult_out}, 16'h0002);
    wr(clkgen_pkg::ADDR_MULT, 16'h000F);
    check("mult max", {11'h000, pll_mult_out}, 16'h000F);
    wr(clkgen_pkg::ADDR_MULT, 16'h0010);
    rd(clkgen_pkg::ADDR_MULT, 16'h0010);
    wr(clkgen_pkg::ADDR_MULT, 16'h0001);
    check("mult held", {11'h000, pll_mult_out}, 16'h000F);
    // retune: release reset with lock input high, then enable the PLL path
    wr(clkgen_pkg::ADDR_CLOCK_MODE_CONTROL, 16'h0000);
    // 1 us at 8 ns per cycle between new settings and reset release
    idle(125);
    pll_lock_in = 1'b1;
    wr(clkgen_pkg::ADDR_CSR, 16'hFF80);
    check("pll reset released", {15'h0000, pll_reset_out}, 16'h0000);
    rd(clkgen_pkg::ADDR_CSR, 16'h0040);
    idle(30);
    rd(clkgen_pkg::ADDR_CSR, 16'h0060);
    wr(clkgen_pkg::ADDR_CSR, 16'h0001);
    check("path enable", {15'h0000, pll_path_enable_out}, 16'h0001);
    rd(clkgen_pkg::ADDR_CSR, 16'h0061);
    // back to bypass in the same write that puts the PLL in reset
    wr(clkgen_pkg::ADDR_CSR, 16'h0008);
    idle(2);
    rd(clkgen_pkg::ADDR_CSR, 16'h0048);
    wr(clkgen_pkg::ADDR_CSR, 16'h0000);
    idle(30);
    rd(clkgen_pkg::ADDR_CSR, 16'h0060);
    wr(clkgen_pkg::ADDR_CSR, 16'h0002);
    check("pll power down", {15'h0000, pll_power_down_out}, 16'h0001);
    idle(2);
    rd(clkgen_pkg::ADDR_CSR, 16'h0042);
    wr(clkgen_pkg::ADDR_CSR, 16'h0000);
    idle(30);
    pll_lock_in = 1'b0;
    idle(4);
    rd(clkgen_pkg::ADDR_CSR, 16'h0040);
    // oscillator power-down, mode 0 waits for the idle flag
    wr(clkgen_pkg::ADDR_CSR, 16'h0004);
    idle(5);
    check("osc waits idle", {15'h0000, osc_power_down_out}, 16'h0000);
    clockgen_idle_flag = 1'b1;
    idle(5);
    check("osc down on idle", {15'h0000, osc_power_down_out}, 16'h0001);
    clockgen_idle_flag = 1'b0;
    wr(clkgen_pkg::ADDR_CSR, 16'h0000);
    idle(30);
    // mode 1 powers down at once
    wr(clkgen_pkg::ADDR_CLOCK_MODE_CONTROL, 16'h0001);
    wr(clkgen_pkg::ADDR_CSR, 16'h0004);
    idle(1);
    check("osc down at once", {15'h0000, osc_power_down_out}, 16'h0001);
    wr(clkgen_pkg::ADDR_CSR, 16'h0000);
    // counter restarts on wake; test mode and disable force the flag
    rd(clkgen_pkg::ADDR_CSR, 16'h0000);
    test_mode = 1'b1;
    idle(4);
    rd(clkgen_pkg::ADDR_CSR, 16'h0040);
    test_mode = 1'b0;
    wr(clkgen_pkg::ADDR_CSR, 16'h0004);
    wr(clkgen_pkg::ADDR_CSR, 16'h0000);
    osc_count_disable = 1'b1;
    idle(4);
    rd(clkgen_pkg::ADDR_CSR, 16'h0040);
    osc_count_disable = 1'b0;
    idle(30);
    rd(clkgen_pkg::ADDR_CSR, 16'h0040);
    check("core clock source", core_clock_source_out, 16'hFFFF);
    check("fast div", {fast_div_enable_out, 10'h000, fast_div_ratio_out}, 16'h801F);
    check("slow div", {slow_div_enable_out, 10'h000, slow_div_ratio_out}, 16'h801F);
    end_of_test();
  end
endmodule : tb
`default_nettype wire
